// ==== logic/pifr_pkg.sv ====
// Constants for the peripheral interrupt flag registers 6 to 8
package pifr_pkg;
   localparam logic [7:0] OFS_FLAGS6 = 8'h00;
   localparam logic [7:0] OFS_FLAGS7 = 8'h04;
   localparam logic [7:0] OFS_FLAGS8 = 8'h08;
   localparam logic [7:0] OFS_PIN_SEL = 8'h0C;
   localparam logic [7:0] OFS_EVT_STATUS = 8'h10;
   localparam logic [7:0] OFS_EVT_CLEAR = 8'h14;
   localparam logic [7:0] OFS_EVT_ENABLE = 8'h18;
   // Register 6 fields
   localparam int B6_TMR3_GATE = 7;
   localparam int B6_TMR3_OVF = 6;
   localparam int B6_UART_GEN = 5;
   localparam int B6_UART_ERR = 4;
   localparam int B6_UART_TX = 3;
   localparam int B6_UART_RX = 2;
   localparam int B6_I2C_ERR = 1;
   localparam int B6_I2C_GEN = 0;
   // Register 7 fields
   localparam int B7_EXT_IRQ2 = 5;
   localparam int B7_LOGIC_CELL2 = 4;
   localparam int B7_WAVE_GEN2 = 3;
   localparam int B7_CAPT_CMP2 = 1;
   localparam int B7_TIMER4 = 0;
   // Register 8 fields
   localparam int B8_TMR5_GATE = 7;
   localparam int B8_TMR5_OVF = 6;
   // Writable (hardware-settable) and implemented masks
   localparam logic [7:0] MASK6_HS = 8'hC0;
   localparam logic [7:0] MASK7_HS = 8'h3B;
   localparam logic [7:0] MASK8_HS = 8'hC0;
   // Reset values
   localparam logic [7:0] RST_FLAGS = 8'h00;
   localparam logic [23:0] RST_EVT = 24'h000000;
   localparam logic [2:0] RST_PIN_SEL = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pifr_pkg

// ==== logic/pifr_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/10ps
module pifr_pin_sync (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_i,
   // Pin and event
   input wire logic pin_i,
   output logic rise_o
);
   import pifr_pkg::*;
   logic meta;
   logic stage2;
   logic stage3;
   logic level;
   wire agree = (stage2 == stage3);
   wire next_level = agree ? stage3 : level;

   // Stage one feeds only stage two
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         meta <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
         level <= 1'b0;
         rise_o <= 1'b0;
      end else begin
         meta <= pin_i;
         stage2 <= meta;
         stage3 <= stage2;
         level <= next_level;
         rise_o <= next_level & ~level;
      end
   end
endmodule : pifr_pin_sync

// ==== logic/pifr_axil_slave.sv ====
// AXI4-Lite slave front end: one write and one read in flight
`timescale 1ns/10ps
module pifr_axil_slave #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_i,
   // Write address and data
   input wire logic [ADDR_W-1:0] s_awaddr_i,
   input wire logic s_awvalid_i,
   output logic s_awready_o,
   input wire logic [31:0] s_wdata_i,
   input wire logic [3:0] s_wstrb_i,
   input wire logic s_wvalid_i,
   output logic s_wready_o,
   // Write response
   output logic [1:0] s_bresp_o,
   output logic s_bvalid_o,
   input wire logic s_bready_i,
   // Read address and data
   input wire logic [ADDR_W-1:0] s_araddr_i,
   input wire logic s_arvalid_i,
   output logic s_arready_o,
   output logic [31:0] s_rdata_o,
   output logic [1:0] s_rresp_o,
   output logic s_rvalid_o,
   input wire logic s_rready_i,
   // Register side
   output logic wr_en_o,
   output logic [ADDR_W-1:0] wr_addr_o,
   output logic [31:0] wr_data_o,
   output logic [3:0] wr_strb_o,
   input wire logic wr_hit_i,
   output logic [ADDR_W-1:0] rd_addr_o,
   input wire logic [31:0] rd_data_i,
   input wire logic rd_hit_i
);
   import pifr_pkg::*;
   logic aw_held;
   logic w_held;
   wire aw_take = s_awvalid_i & s_awready_o;
   wire w_take = s_wvalid_i & s_wready_o;
   wire ar_take = s_arvalid_i & s_arready_o;

   // Readies are registered from next state so the bus outputs leave flops
   wire next_aw_held = ~wr_en_o & (aw_held | aw_take);
   wire next_w_held = ~wr_en_o & (w_held | w_take);
   wire next_bvalid = wr_en_o | (s_bvalid_o & ~s_bready_i);
   wire next_rvalid = ar_take | (s_rvalid_o & ~s_rready_i);
   assign wr_en_o = aw_held & w_held & ~s_bvalid_o;
   assign rd_addr_o = s_araddr_i;

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         wr_addr_o <= '0;
         wr_data_o <= 32'h00000000;
         wr_strb_o <= 4'h0;
         s_bvalid_o <= 1'b0;
         s_bresp_o <= RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_held <= 1'b1;
            wr_addr_o <= s_awaddr_i;
         end
         if (w_take) begin
            w_held <= 1'b1;
            wr_data_o <= s_wdata_i;
            wr_strb_o <= s_wstrb_i;
         end
         // Address and data may arrive in either order; act once both are held
         if (wr_en_o) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_bvalid_o <= 1'b1;
            s_bresp_o <= wr_hit_i ? RESP_OKAY : RESP_SLVERR;
         end else if (s_bvalid_o && s_bready_i) begin
            s_bvalid_o <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         s_rvalid_o <= 1'b0;
         s_rdata_o <= 32'h00000000;
         s_rresp_o <= RESP_OKAY;
      end else if (ar_take) begin
         s_rvalid_o <= 1'b1;
         s_rdata_o <= rd_hit_i ? rd_data_i : 32'h00000000;
         s_rresp_o <= rd_hit_i ? RESP_OKAY : RESP_SLVERR;
      end else if (s_rvalid_o && s_rready_i) begin
         s_rvalid_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         s_awready_o <= 1'b1;
         s_wready_o <= 1'b1;
         s_arready_o <= 1'b1;
      end else begin
         s_awready_o <= ~next_aw_held & ~next_bvalid;
         s_wready_o <= ~next_w_held & ~next_bvalid;
         s_arready_o <= ~next_rvalid;
      end
   end
endmodule : pifr_axil_slave

// ==== logic/pifr_top.sv ====
// Peripheral interrupt flag registers 6 to 8 with AXI4-Lite access
`timescale 1ns/10ps
module pifr_top #(
   parameter int PIN_COUNT = 8,
   parameter int SEL_W = 3
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_i,
   // AXI4-Lite write channels
   input wire logic [7:0] s_awaddr_i,
   input wire logic s_awvalid_i,
   output logic s_awready_o,
   input wire logic [31:0] s_wdata_i,
   input wire logic [3:0] s_wstrb_i,
   input wire logic s_wvalid_i,
   output logic s_wready_o,
   output logic [1:0] s_bresp_o,
   output logic s_bvalid_o,
   input wire logic s_bready_i,
   // AXI4-Lite read channels
   input wire logic [7:0] s_araddr_i,
   input wire logic s_arvalid_i,
   output logic s_arready_o,
   output logic [31:0] s_rdata_o,
   output logic [1:0] s_rresp_o,
   output logic s_rvalid_o,
   input wire logic s_rready_i,
   // Hardware set pulses, system clock domain
   input wire logic timer3_gate_set_i,
   input wire logic timer3_ovf_set_i,
   input wire logic logic_cell2_set_i,
   input wire logic waveform_gen2_set_i,
   input wire logic capture_compare2_set_i,
   input wire logic timer4_match_set_i,
   input wire logic timer5_gate_set_i,
   input wire logic timer5_ovf_set_i,
   // Peripheral status, system clock domain
   input wire logic [7:0] uart_irq_status_reg_i,
   input wire logic [7:0] uart_error_status_reg_i,
   input wire logic uart_tx_buf_ready_i,
   input wire logic uart_rx_buf_full_i,
   input wire logic [7:0] i2c_error_status_reg_i,
   input wire logic [7:0] i2c_irq_status_reg_i,
   // External interrupt pins, asynchronous
   input wire logic [PIN_COUNT-1:0] ext_pins_i,
   // Flags towards the priority logic and interrupt
   output logic [7:0] periph_irq_flags_6_o,
   output logic [7:0] periph_irq_flags_7_o,
   output logic [7:0] periph_irq_flags_8_o,
   output logic irq_o
);
   import pifr_pkg::*;

   logic [7:0] periph_irq_flags_6;
   logic [7:0] periph_irq_flags_7;
   logic [7:0] periph_irq_flags_8;
   logic [SEL_W-1:0] ext_irq_pin_select;
   logic [23:0] evt_status;
   logic [23:0] evt_enable;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic [7:0] rd_addr;
   logic ext_irq2_rise;
   logic wr_hit;
   logic rd_hit;
   logic [31:0] rd_data;

   // Software write with hardware set on top, so a set in the clear cycle wins
   function automatic logic [7:0] flag_update(
      input logic [7:0] cur,
      input logic [7:0] hw_set,
      input logic wr,
      input logic [7:0] wd,
      input logic [7:0] mask
   );
      flag_update = (hw_set | (wr ? wd : cur)) & mask;
   endfunction : flag_update

   function automatic logic [31:0] strb_mask(input logic [3:0] strb);
      strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction : strb_mask

   pifr_axil_slave #(
      .ADDR_W(8)
   ) u_bus (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .s_awaddr_i(s_awaddr_i),
      .s_awvalid_i(s_awvalid_i),
      .s_awready_o(s_awready_o),
      .s_wdata_i(s_wdata_i),
      .s_wstrb_i(s_wstrb_i),
      .s_wvalid_i(s_wvalid_i),
      .s_wready_o(s_wready_o),
      .s_bresp_o(s_bresp_o),
      .s_bvalid_o(s_bvalid_o),
      .s_bready_i(s_bready_i),
      .s_araddr_i(s_araddr_i),
      .s_arvalid_i(s_arvalid_i),
      .s_arready_o(s_arready_o),
      .s_rdata_o(s_rdata_o),
      .s_rresp_o(s_rresp_o),
      .s_rvalid_o(s_rvalid_o),
      .s_rready_i(s_rready_i),
      .wr_en_o(wr_en),
      .wr_addr_o(wr_addr),
      .wr_data_o(wr_data),
      .wr_strb_o(wr_strb),
      .wr_hit_i(wr_hit),
      .rd_addr_o(rd_addr),
      .rd_data_i(rd_data),
      .rd_hit_i(rd_hit)
   );

   // Pin chosen by software; a select change may itself look like an edge
   wire sel_pin = ext_pins_i[ext_irq_pin_select];

   pifr_pin_sync u_ext_sync (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .pin_i(sel_pin),
      .rise_o(ext_irq2_rise)
   );

   // Address decode
   wire hit_f6 = (wr_addr == OFS_FLAGS6);
   wire hit_f7 = (wr_addr == OFS_FLAGS7);
   wire hit_f8 = (wr_addr == OFS_FLAGS8);
   wire hit_sel = (wr_addr == OFS_PIN_SEL);
   wire hit_clr = (wr_addr == OFS_EVT_CLEAR);
   wire hit_en = (wr_addr == OFS_EVT_ENABLE);
   wire hit_st = (wr_addr == OFS_EVT_STATUS);
   assign wr_hit = hit_f6 | hit_f7 | hit_f8 | hit_sel | hit_clr | hit_en | hit_st;
   wire wr6 = wr_en & hit_f6 & wr_strb[0];
   wire wr7 = wr_en & hit_f7 & wr_strb[0];
   wire wr8 = wr_en & hit_f8 & wr_strb[0];
   wire wr_sel = wr_en & hit_sel & wr_strb[0];
   wire wr_clr = wr_en & hit_clr;
   wire wr_ena = wr_en & hit_en;
   wire [31:0] wmask = strb_mask(wr_strb);

   // Hardware set vectors in field order
   wire [7:0] hs6 = {timer3_gate_set_i, timer3_ovf_set_i, 6'h00};
   wire [7:0] hs7 = {2'h0, ext_irq2_rise, logic_cell2_set_i, waveform_gen2_set_i, 1'h0,
                     capture_compare2_set_i, timer4_match_set_i};
   wire [7:0] hs8 = {timer5_gate_set_i, timer5_ovf_set_i, 6'h00};

   // Mirrored bits follow peripheral state; writes never reach them
   wire [7:0] ro6 = {2'h0,
                     |uart_irq_status_reg_i,
                     |uart_error_status_reg_i,
                     uart_tx_buf_ready_i, uart_rx_buf_full_i,
                     |i2c_error_status_reg_i,
                     |i2c_irq_status_reg_i};

   wire [7:0] next_flags6 = flag_update(periph_irq_flags_6, hs6, wr6, wr_data[7:0], MASK6_HS) | ro6;
   wire [7:0] next_flags7 = flag_update(periph_irq_flags_7, hs7, wr7, wr_data[7:0], MASK7_HS);
   wire [7:0] next_flags8 = flag_update(periph_irq_flags_8, hs8, wr8, wr_data[7:0], MASK8_HS);

   // Any flag rising is an event for the summary interrupt
   wire [23:0] flags_now = {periph_irq_flags_8, periph_irq_flags_7, periph_irq_flags_6};
   wire [23:0] flags_next = {next_flags8, next_flags7, next_flags6};
   wire [23:0] evt_rise = flags_next & ~flags_now;
   wire [23:0] evt_clr = wr_clr ? (wr_data[23:0] & wmask[23:0]) : 24'h000000;
   wire [23:0] next_evt_status = (evt_status & ~evt_clr) | evt_rise;
   wire [23:0] next_evt_enable = wr_ena ? ((wr_data[23:0] & wmask[23:0]) | (evt_enable & ~wmask[23:0]))
                                        : evt_enable;

   // Read decode; the clear register reads as zero
   assign rd_hit = (rd_addr == OFS_FLAGS6) | (rd_addr == OFS_FLAGS7) | (rd_addr == OFS_FLAGS8) |
                 (rd_addr == OFS_PIN_SEL) | (rd_addr == OFS_EVT_STATUS) |
                 (rd_addr == OFS_EVT_CLEAR) | (rd_addr == OFS_EVT_ENABLE);
   assign rd_data = (rd_addr == OFS_FLAGS6) ? {24'h000000, periph_irq_flags_6} :
                         (rd_addr == OFS_FLAGS7) ? {24'h000000, periph_irq_flags_7} :
                         (rd_addr == OFS_FLAGS8) ? {24'h000000, periph_irq_flags_8} :
                         (rd_addr == OFS_PIN_SEL) ? {{(32-SEL_W){1'b0}}, ext_irq_pin_select} :
                         (rd_addr == OFS_EVT_STATUS) ? {8'h00, evt_status} :
                         (rd_addr == OFS_EVT_ENABLE) ? {8'h00, evt_enable} : 32'h00000000;

   // Flags clear on every reset source
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         periph_irq_flags_6 <= RST_FLAGS;
         periph_irq_flags_7 <= RST_FLAGS;
         periph_irq_flags_8 <= RST_FLAGS;
      end else begin
         periph_irq_flags_6 <= next_flags6;
         periph_irq_flags_7 <= next_flags7;
         periph_irq_flags_8 <= next_flags8;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         ext_irq_pin_select <= RST_PIN_SEL;
         evt_status <= RST_EVT;
         evt_enable <= RST_EVT;
         irq_o <= 1'b0;
      end else begin
         if (wr_sel) begin
            ext_irq_pin_select <= wr_data[SEL_W-1:0];
         end
         evt_status <= next_evt_status;
         evt_enable <= next_evt_enable;
         // Registered for a clean output; one cycle behind the status
         irq_o <= |(evt_status & evt_enable);
      end
   end

   // Enable gating per flag lives in the priority logic downstream
   assign periph_irq_flags_6_o = periph_irq_flags_6;
   assign periph_irq_flags_7_o = periph_irq_flags_7;
   assign periph_irq_flags_8_o = periph_irq_flags_8;

   a_hw_set_flag: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      timer3_ovf_set_i |=> periph_irq_flags_6[B6_TMR3_OVF])
      else $error("timer3 overflow set did not raise its flag");

   a_flag_sticky: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      periph_irq_flags_7[B7_TIMER4] && !wr7 |=> periph_irq_flags_7[B7_TIMER4])
      else $error("timer4 flag dropped without a write");

   a_write_clears: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      wr8 && !wr_data[B8_TMR5_GATE] && !timer5_gate_set_i |=> !periph_irq_flags_8[B8_TMR5_GATE])
      else $error("timer5 gate flag not cleared by zero write");

   a_uart_gen_mirror: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      ##1 periph_irq_flags_6[B6_UART_GEN] == |$past(uart_irq_status_reg_i))
      else $error("uart general flag does not follow its status");

   a_uart_err_mirror: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      uart_error_status_reg_i == 8'h00 |=> !periph_irq_flags_6[B6_UART_ERR])
      else $error("uart error flag stuck with status clear");

   a_uart_buf_mirror: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      wr6 |=> periph_irq_flags_6[B6_UART_TX:B6_UART_RX] ==
              {$past(uart_tx_buf_ready_i), $past(uart_rx_buf_full_i)})
      else $error("uart buffer flags changed by a write");

   a_i2c_err_mirror: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      $rose(|i2c_error_status_reg_i) |=> periph_irq_flags_6[B6_I2C_ERR])
      else $error("i2c error flag missed its status");

   a_i2c_gen_mirror: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      i2c_irq_status_reg_i == 8'h00 |=> !periph_irq_flags_6[B6_I2C_GEN])
      else $error("i2c general flag stuck with status clear");

   a_unimpl_zero: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (periph_irq_flags_7 & ~MASK7_HS) == 8'h00 && (periph_irq_flags_8 & ~MASK8_HS) == 8'h00)
      else $error("unimplemented flag bit reads one");

   a_reset_clear: assert property (@(posedge clk_sys_i)
      reset_i |=> flags_now == 24'h000000 && !irq_o)
      else $error("flags not cleared by reset");

   a_irq_follow: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      ##1 irq_o == |($past(evt_status) & $past(evt_enable)))
      else $error("interrupt output does not follow enabled status");

   a_t3_gate_set: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      timer3_gate_set_i |=> periph_irq_flags_6[B6_TMR3_GATE])
      else $error("timer3 gate set did not raise its flag");

   a_ext_irq_set: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      ext_irq2_rise |=> periph_irq_flags_7[B7_EXT_IRQ2])
      else $error("pin edge did not raise the ext irq flag");

   a_t5_ovf_set: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      timer5_ovf_set_i |=> periph_irq_flags_8[B8_TMR5_OVF])
      else $error("timer5 overflow set did not raise its flag");

   a_write_one_sets: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      wr7 && wr_data[B7_WAVE_GEN2] |=> periph_irq_flags_7[B7_WAVE_GEN2])
      else $error("writing one did not set the waveform flag");

   a_t3_ovf_sticky: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      periph_irq_flags_6[B6_TMR3_OVF] && !wr6 |=> periph_irq_flags_6[B6_TMR3_OVF])
      else $error("timer3 flag dropped without a write");

   a_cell_clear: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      wr7 && !wr_data[B7_LOGIC_CELL2] && !logic_cell2_set_i |=> !periph_irq_flags_7[B7_LOGIC_CELL2])
      else $error("logic cell flag not cleared by zero write");

   a_uart_gen_clear: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      uart_irq_status_reg_i == 8'h00 |=> !periph_irq_flags_6[B6_UART_GEN])
      else $error("uart general flag stuck with status clear");

   a_uart_err_set: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (|uart_error_status_reg_i) |=> periph_irq_flags_6[B6_UART_ERR])
      else $error("uart error flag missed its status");

   a_i2c_err_clear: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      i2c_error_status_reg_i == 8'h00 |=> !periph_irq_flags_6[B6_I2C_ERR])
      else $error("i2c error flag stuck with status clear");

   a_i2c_gen_set: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (|i2c_irq_status_reg_i) |=> periph_irq_flags_6[B6_I2C_GEN])
      else $error("i2c general flag missed its status");
endmodule : pifr_top

// ==== verification/pifr_periph_model.sv ====
// Model of the peripherals that raise events into the flag block
`timescale 1ns/10ps
module pifr_periph_model (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_i,
   // Requests from the bench
   input wire logic [7:0] fire_i,
   input wire logic [2:0] pin_idx_i,
   input wire logic pin_lvl_i,
   // Towards the flag block
   output logic [7:0] set_o,
   output logic [7:0] pins_o
);
   // One-cycle event pulses, raised with no regard to any enable
   always_ff @(posedge clk_sys_i) begin
      set_o <= reset_i ? 8'h00 : fire_i;
   end
   // Only the addressed pin moves, so a wrong pin select shows up
   always_comb begin
      pins_o = 8'h00;
      pins_o[pin_idx_i] = pin_lvl_i;
   end
endmodule : pifr_periph_model

// ==== verification/peripheral_irq_flag_regs_6_8_bench.sv ====
// Self-checking bench for the peripheral interrupt flag registers
`timescale 1ns/10ps
module peripheral_irq_flag_regs_6_8_bench;
   import pifr_pkg::*;
   localparam logic [23:0] EXP_TAB [8] = '{24'h000100, 24'h000200, 24'h400000, 24'h000800,
                                            24'h001000, 24'h800000, 24'h000040, 24'h000080};
   logic clk_sys_i = 1'b0;
   logic reset_i = 1'b1;
   logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
   logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
   logic [31:0] s_wdata = 32'h0, s_rdata;
   logic [3:0] s_wstrb = 4'hF;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
   logic [1:0] s_bresp, s_rresp;
   logic [7:0] fire = 8'h00, set_w, pins_w, f6, f7, f8;
   logic [7:0] u_irq = 8'h00, u_err = 8'h00, i_err = 8'h00, i_irq = 8'h00;
   logic tx_rdy = 1'b0, rx_full = 1'b0, pin_lvl = 1'b0;
   logic [2:0] pin_idx = 3'h0;
   logic [23:0] acc;
   int errors = 0, total_checks = 0, cycles = 0;

   pifr_top u_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .s_awaddr_i(s_awaddr), .s_awvalid_i(s_awvalid), .s_awready_o(s_awready),
      .s_wdata_i(s_wdata), .s_wstrb_i(s_wstrb), .s_wvalid_i(s_wvalid), .s_wready_o(s_wready),
      .s_bresp_o(s_bresp), .s_bvalid_o(s_bvalid), .s_bready_i(s_bready),
      .s_araddr_i(s_araddr), .s_arvalid_i(s_arvalid), .s_arready_o(s_arready),
      .s_rdata_o(s_rdata), .s_rresp_o(s_rresp), .s_rvalid_o(s_rvalid), .s_rready_i(s_rready),
      .timer4_match_set_i(set_w[0]), .capture_compare2_set_i(set_w[1]), .timer3_ovf_set_i(set_w[2]),
      .waveform_gen2_set_i(set_w[3]), .logic_cell2_set_i(set_w[4]), .timer3_gate_set_i(set_w[5]),
      .timer5_ovf_set_i(set_w[6]), .timer5_gate_set_i(set_w[7]),
      .uart_irq_status_reg_i(u_irq), .uart_error_status_reg_i(u_err), .uart_tx_buf_ready_i(tx_rdy),
      .uart_rx_buf_full_i(rx_full), .i2c_error_status_reg_i(i_err), .i2c_irq_status_reg_i(i_irq),
      .ext_pins_i(pins_w), .periph_irq_flags_6_o(f6), .periph_irq_flags_7_o(f7),
      .periph_irq_flags_8_o(f8), .irq_o(irq));

   pifr_periph_model u_model (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .fire_i(fire),
      .pin_idx_i(pin_idx), .pin_lvl_i(pin_lvl), .set_o(set_w), .pins_o(pins_w));

   initial begin
      forever #25 clk_sys_i = ~clk_sys_i;
   end

   task automatic conclude();
      $display("Checks made: %0d, mismatches: %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude

   // Generous ceiling; the whole sequence needs well under a thousand cycles
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         $display("ERROR at %0t: timeout", $time);
         conclude();
      end
   end

   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask : settle

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk_sys_i);
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk_sys_i);
         if (!aw_ok && s_awready === 1'b1) begin
            aw_ok = 1'b1;
            s_awvalid <= 1'b0;
         end
         if (!w_ok && s_wready === 1'b1) begin
            w_ok = 1'b1;
            s_wvalid <= 1'b0;
         end
      end
      do @(posedge clk_sys_i); while (s_bvalid !== 1'b1);
      s_bready <= 1'b0;
      chk({30'h0, s_bresp}, {30'h0, er});
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge clk_sys_i);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do @(posedge clk_sys_i); while (s_arready !== 1'b1);
      s_arvalid <= 1'b0;
      do @(posedge clk_sys_i); while (s_rvalid !== 1'b1);
      s_rready <= 1'b0;
      chk(s_rdata, exp);
      chk({30'h0, s_rresp}, {30'h0, er});
   endtask : rd_chk

   // Request pulses from the model, then let the flags land
   task automatic pulse(input logic [7:0] m);
      @(posedge clk_sys_i);
      fire <= m;
      @(posedge clk_sys_i);
      fire <= 8'h00;
      settle(2);
   endtask : pulse

   initial begin
      repeat (2) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      rd_chk(OFS_FLAGS6, 32'h0, RESP_OKAY);
      rd_chk(OFS_FLAGS7, 32'h0, RESP_OKAY);
      rd_chk(OFS_FLAGS8, 32'h0, RESP_OKAY);
      rd_chk(OFS_EVT_ENABLE, 32'h0, RESP_OKAY);
      $display("Test reset values done");
      // Each of the eight model set sources in turn (pin source not included), all enables off; earlier flags must stay
      acc = 24'h0;
      for (int i = 0; i < 8; i++) begin
         pulse(8'h01 << i);
         acc = acc | EXP_TAB[i];
         chk({8'h00, f6, f7, f8}, {8'h00, acc});
      end
      rd_chk(OFS_FLAGS6, 32'hC0, RESP_OKAY);
      rd_chk(OFS_FLAGS7, 32'h1B, RESP_OKAY);
      rd_chk(OFS_FLAGS8, 32'hC0, RESP_OKAY);
      rd_chk(OFS_EVT_STATUS, 32'hC01BC0, RESP_OKAY);
      $display("Test event sources done");
      wr(OFS_FLAGS7, 32'h0, RESP_OKAY);
      rd_chk(OFS_FLAGS7, 32'h0, RESP_OKAY);
      wr(OFS_FLAGS7, 32'hFF, RESP_OKAY);
      rd_chk(OFS_FLAGS7, 32'h3B, RESP_OKAY);
      wr(OFS_FLAGS8, 32'hFF, RESP_OKAY);
      rd_chk(OFS_FLAGS8, 32'hC0, RESP_OKAY);
      // Byte lane 0 off: the write is accepted but must not touch the flags
      s_wstrb <= 4'hE;
      wr(OFS_FLAGS8, 32'h0, RESP_OKAY);
      s_wstrb <= 4'hF;
      rd_chk(OFS_FLAGS8, 32'hC0, RESP_OKAY);
      wr(OFS_FLAGS6, 32'h3F, RESP_OKAY);
      rd_chk(OFS_FLAGS6, 32'h0, RESP_OKAY);
      wr(OFS_FLAGS7, 32'h0, RESP_OKAY);
      wr(OFS_FLAGS8, 32'h0, RESP_OKAY);
      rd_chk(OFS_FLAGS8, 32'h0, RESP_OKAY);
      $display("Test software writes done");
      @(posedge clk_sys_i);
      u_irq <= 8'h81;
      u_err <= 8'h01;
      tx_rdy <= 1'b1;
      rx_full <= 1'b1;
      i_err <= 8'h10;
      i_irq <= 8'h02;
      settle(2);
      chk({24'h0, f6}, 32'h3F);
      wr(OFS_FLAGS6, 32'h0, RESP_OKAY);
      rd_chk(OFS_FLAGS6, 32'h3F, RESP_OKAY);
      @(posedge clk_sys_i);
      u_irq <= 8'h01;
      u_err <= 8'h00;
      tx_rdy <= 1'b0;
      i_irq <= 8'h00;
      settle(2);
      chk({24'h0, f6}, 32'h26);
      @(posedge clk_sys_i);
      u_irq <= 8'h00;
      rx_full <= 1'b0;
      i_err <= 8'h00;
      settle(2);
      chk({24'h0, f6}, 32'h0);
      $display("Test mirror flags done");
      wr(OFS_PIN_SEL, 32'h3, RESP_OKAY);
      rd_chk(OFS_PIN_SEL, 32'h3, RESP_OKAY);
      @(posedge clk_sys_i);
      pin_idx <= 3'h5;
      pin_lvl <= 1'b1;
      settle(10);
      chk({24'h0, f7}, 32'h0);
      @(posedge clk_sys_i);
      pin_lvl <= 1'b0;
      pin_idx <= 3'h3;
      settle(4);
      @(posedge clk_sys_i);
      pin_lvl <= 1'b1;
      settle(10);
      chk({24'h0, f7}, 32'h20);
      $display("Test pin select done");
      // Stale flag and event cleared before the enable goes on
      wr(OFS_FLAGS7, 32'h0, RESP_OKAY);
      wr(OFS_EVT_CLEAR, 32'hFFFFFF, RESP_OKAY);
      rd_chk(OFS_EVT_STATUS, 32'h0, RESP_OKAY);
      wr(OFS_EVT_ENABLE, 32'h100, RESP_OKAY);
      rd_chk(OFS_EVT_ENABLE, 32'h100, RESP_OKAY);
      settle(1);
      chk({31'h0, irq}, 32'h0);
      pulse(8'h04);
      chk({31'h0, irq}, 32'h0);
      rd_chk(OFS_EVT_STATUS, 32'h40, RESP_OKAY);
      pulse(8'h01);
      chk({31'h0, irq}, 32'h1);
      wr(OFS_EVT_CLEAR, 32'h100, RESP_OKAY);
      settle(2);
      chk({31'h0, irq}, 32'h0);
      rd_chk(OFS_EVT_STATUS, 32'h40, RESP_OKAY);
      wr(8'h20, 32'hFF, RESP_SLVERR);
      rd_chk(8'h20, 32'h0, RESP_SLVERR);
      $display("Test interrupt and unmapped done");
      // Timer4 flag is still set; clear it so the next pulse is a fresh event
      wr(OFS_FLAGS7, 32'h0, RESP_OKAY);
      pulse(8'hFF);
      chk({31'h0, irq}, 32'h1);
      @(posedge clk_sys_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      settle(1);
      chk({7'h0, irq, f6, f7, f8}, 32'h0);
      rd_chk(OFS_EVT_STATUS, 32'h0, RESP_OKAY);
      rd_chk(OFS_FLAGS7, 32'h0, RESP_OKAY);
      $display("Test reset in mid-run done");
      conclude();
   end
endmodule : peripheral_irq_flag_regs_6_8_bench
